// ---- agpm_pkg.sv ----
// Package of constants for the address and port line pin mux.
package agpm_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] AGPM_OFF_BUS_CTRL   = 8'h00;
  localparam logic [7:0] AGPM_OFF_FUNC_SEL   = 8'h04;
  localparam logic [7:0] AGPM_OFF_PA_PULLUP  = 8'h08;
  localparam logic [7:0] AGPM_OFF_PE_PULLUP  = 8'h0C;
  localparam logic [7:0] AGPM_OFF_PA_DIR     = 8'h10;
  localparam logic [7:0] AGPM_OFF_PA_DATA    = 8'h14;
  localparam logic [7:0] AGPM_OFF_PE_DIR     = 8'h18;
  localparam logic [7:0] AGPM_OFF_PE_DATA    = 8'h1C;
  localparam logic [7:0] AGPM_OFF_PIN_STATE  = 8'h20;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int AGPM_NPINS      = 8;
  localparam int AGPM_PA_LO      = 8;   // Port A line of address bit zero.
  localparam int AGPM_PA_HI      = 13;  // Port A line of address bit five.
  localparam int AGPM_PE_LO      = 2;   // Port E line of address bit six.
  localparam int AGPM_PE_HI      = 3;   // Port E line of address bit seven.
  localparam int AGPM_DRV_BIT    = 0;   // Bus drive select in the bus control register.

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic        AGPM_DRV_RST   = 1'h0;
  localparam logic [7:0]  AGPM_FSEL_RST  = 8'h00;   // All pins on the address bus.
  localparam logic [15:0] AGPM_PA_PU_RST = 16'hFFFF;
  localparam logic [15:0] AGPM_PE_PU_RST = 16'hFFFF;
  localparam logic [15:0] AGPM_ZERO16    = 16'h0000;

  // AXI response codes.
  localparam logic [1:0]  AGPM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  AGPM_RESP_SLVERR = 2'h2;

endpackage

// ---- agpm_sync2.sv ----
// Two-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module agpm_sync2 import agpm_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // Only the second stage is visible; the first stage feeds nothing else.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      q_reg    <= '0;
    end else begin
      meta_reg <= d;
      q_reg    <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// ---- agpm_pin_cell.sv ----
// One shared pin: function select, drive enable and pull-up.
`timescale 1ns/1ps
module agpm_pin_cell import agpm_pkg::*; (
  input  wire logic fsel_gpio,
  input  wire logic in_reset,
  input  wire logic bus_addr,
  input  wire logic bus_drive,
  input  wire logic gpio_dir_out,
  input  wire logic gpio_data,
  input  wire logic pullup_bit,
  output logic      pin_o,
  output logic      pin_oe,
  output logic      pin_pu
);

  // Selects between the address bus and the port line for this pin.
  always_comb begin
    if (in_reset) begin
      pin_o  = 1'b0;
      pin_oe = 1'b0;
      pin_pu = 1'b1;
    end else begin
      pin_o  = fsel_gpio ? gpio_data : bus_addr;
      pin_oe = fsel_gpio ? gpio_dir_out : bus_drive;
      pin_pu = pullup_bit;
    end
  end

endmodule

// ---- agpm_top.sv ----
// Pin mux for address lines zero to seven shared with port A and port E.
`timescale 1ns/1ps
module agpm_top import agpm_pkg::*; (
  input  wire logic        mclk,
  input  wire logic        resetn,
  // AXI4-Lite slave.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // External memory interface side.
  input  wire logic [7:0]  emi_addr,
  input  wire logic        emi_access,
  // Pads.
  input  wire logic [7:0]  pad_i,
  output logic [7:0]       pad_o,
  output logic [7:0]       pad_oe,
  output logic [7:0]       pad_pu
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  // Every writable register keeps a _reg copy and a _next value.
  // Port line registers are 16 bits wide although only a few lines reach
  // these pads; the other bits read back as written, so software can keep
  // one image of each port for all of its lines.
  logic        drv_reg, drv_next;
  logic [7:0]  fsel_reg, fsel_next;
  logic [15:0] pa_pu_reg, pa_pu_next;
  logic [15:0] pe_pu_reg, pe_pu_next;
  logic [15:0] pa_dir_reg, pa_dir_next;
  logic [15:0] pa_dat_reg, pa_dat_next;
  logic [15:0] pe_dir_reg, pe_dir_next;
  logic [15:0] pe_dat_reg, pe_dat_next;
  logic        aw_got_reg, aw_got_next;
  logic        w_got_reg, w_got_next;
  logic [7:0]  aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0]  w_strb_reg, w_strb_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        rst_seen_reg;
  logic [7:0]  pin_sync;

  // ----------------------------------------------------------------
  // Pin input synchroniser and reset-state flag
  // ----------------------------------------------------------------
  agpm_sync2 #(.W(AGPM_NPINS)) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .d      (pad_i),
    .q      (pin_sync)
  );

  // Holds the pads in their reset state until the first edge after release.
  // Without it the pads would switch to the bus function in the middle of a
  // clock period, while the registers are still leaving reset.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin mapping
  // ----------------------------------------------------------------
  logic [7:0] bus_drive;
  logic [7:0] g_dir;
  logic [7:0] g_dat;
  logic [7:0] g_pu;

  // Idle bus pins float unless software chose to keep them driven.
  // With the drive select at its reset value the memory sees pull-up levels
  // on these lines between accesses only where the pull-up bit is set.
  assign bus_drive = {AGPM_NPINS{emi_access | drv_reg}};
  // Low six pins use port A lines 8..13, top two use port E lines 2..3.
  assign g_dir = {pe_dir_reg[AGPM_PE_HI:AGPM_PE_LO], pa_dir_reg[AGPM_PA_HI:AGPM_PA_LO]};
  assign g_dat = {pe_dat_reg[AGPM_PE_HI:AGPM_PE_LO], pa_dat_reg[AGPM_PA_HI:AGPM_PA_LO]};
  assign g_pu  = {pe_pu_reg[AGPM_PE_HI:AGPM_PE_LO],
                  pa_pu_reg[AGPM_PA_HI:AGPM_PA_LO]};

  // One pin cell per pad; the reset state overrides both functions, and the
  // pull-up follows its register bit whichever function is selected.
  genvar gi;
  generate
    for (gi = 0; gi < AGPM_NPINS; gi++) begin : g_pin
      agpm_pin_cell u_cell (
        .fsel_gpio    (fsel_reg[gi]),
        .in_reset     (~rst_seen_reg),
        .bus_addr     (emi_addr[gi]),
        .bus_drive    (bus_drive[gi]),
        .gpio_dir_out (g_dir[gi]),
        .gpio_data    (g_dat[gi]),
        .pullup_bit   (g_pu[gi]),
        .pin_o        (pad_o[gi]),
        .pin_oe       (pad_oe[gi]),
        .pin_pu       (pad_pu[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Byte-lane merge helper
  // ----------------------------------------------------------------
  // Only the two low byte lanes hold state; the upper lanes of a write are
  // dropped without an error response.
  function automatic logic [15:0] agpm_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  st);
    logic [15:0] r;
    r = old_v;
    if (st[0]) r[7:0]  = wd[7:0];
    if (st[1]) r[15:8] = wd[15:8];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  // Address and data are held until both are in; both ready signals stay low
  // from then until the response has been taken, so a second write can never
  // overtake the first.
  logic wr_fire;
  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_fire       = aw_got_reg & w_got_reg & ~bvalid_reg;

  // Captures address and data in either order, then writes one register.
  // A write to an unmapped offset answers with a slave error and changes
  // nothing; the response always comes one edge after the later half.
  always_comb begin
    aw_got_next  = aw_got_reg;
    w_got_next   = w_got_reg;
    aw_addr_next = aw_addr_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    drv_next     = drv_reg;
    fsel_next    = fsel_reg;
    pa_pu_next   = pa_pu_reg;
    pe_pu_next   = pe_pu_reg;
    pa_dir_next  = pa_dir_reg;
    pa_dat_next  = pa_dat_reg;
    pe_dir_next  = pe_dir_reg;
    pe_dat_next  = pe_dat_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_next  = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_next  = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = AGPM_RESP_OKAY;
      case (aw_addr_reg)
        AGPM_OFF_BUS_CTRL: begin
          if (w_strb_reg[0]) drv_next = w_data_reg[AGPM_DRV_BIT];
        end
        AGPM_OFF_FUNC_SEL: begin
          if (w_strb_reg[0]) fsel_next = w_data_reg[7:0];
        end
        AGPM_OFF_PA_PULLUP: pa_pu_next  = agpm_merge(pa_pu_reg, w_data_reg, w_strb_reg);
        AGPM_OFF_PE_PULLUP: pe_pu_next  = agpm_merge(pe_pu_reg, w_data_reg, w_strb_reg);
        AGPM_OFF_PA_DIR:    pa_dir_next = agpm_merge(pa_dir_reg, w_data_reg, w_strb_reg);
        AGPM_OFF_PA_DATA:   pa_dat_next = agpm_merge(pa_dat_reg, w_data_reg, w_strb_reg);
        AGPM_OFF_PE_DIR:    pe_dir_next = agpm_merge(pe_dir_reg, w_data_reg, w_strb_reg);
        AGPM_OFF_PE_DATA:   pe_dat_next = agpm_merge(pe_dat_reg, w_data_reg, w_strb_reg);
        AGPM_OFF_PIN_STATE: bresp_next  = AGPM_RESP_OKAY;             // Read-only, write ignored.
        default:            bresp_next  = AGPM_RESP_SLVERR;
      endcase
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
  end

  // Registers the write path and the configuration; reset gives bus function.
  // The configuration takes its reset values asynchronously, so the pads are
  // safe as soon as reset asserts, with or without a running clock.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= AGPM_RESP_OKAY;
      drv_reg     <= AGPM_DRV_RST;
      fsel_reg    <= AGPM_FSEL_RST;
      pa_pu_reg   <= AGPM_PA_PU_RST;
      pe_pu_reg   <= AGPM_PE_PU_RST;
      pa_dir_reg  <= AGPM_ZERO16;
      pa_dat_reg  <= AGPM_ZERO16;
      pe_dir_reg  <= AGPM_ZERO16;
      pe_dat_reg  <= AGPM_ZERO16;
    end else begin
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      aw_addr_reg <= aw_addr_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      drv_reg     <= drv_next;
      fsel_reg    <= fsel_next;
      pa_pu_reg   <= pa_pu_next;
      pe_pu_reg   <= pe_pu_next;
      pa_dir_reg  <= pa_dir_next;
      pa_dat_reg  <= pa_dat_next;
      pe_dir_reg  <= pe_dir_next;
      pe_dat_reg  <= pe_dat_next;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  // A read is answered on the same edge that takes its address; the answer stands
  // until rready is seen, and no new address is taken while it stands.
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Decodes a read address; the pin state register shows synchronised pads.
  // Pad levels appear there two edges late, after the synchroniser.
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = AGPM_RESP_OKAY;
      case (s_axi_araddr)
        AGPM_OFF_BUS_CTRL:  rdata_next = {31'h0000_0000, drv_reg};
        AGPM_OFF_FUNC_SEL:  rdata_next = {24'h00_0000, fsel_reg};
        AGPM_OFF_PA_PULLUP: rdata_next = {AGPM_ZERO16, pa_pu_reg};
        AGPM_OFF_PE_PULLUP: rdata_next = {AGPM_ZERO16, pe_pu_reg};
        AGPM_OFF_PA_DIR:    rdata_next = {AGPM_ZERO16, pa_dir_reg};
        AGPM_OFF_PA_DATA:   rdata_next = {AGPM_ZERO16, pa_dat_reg};
        AGPM_OFF_PE_DIR:    rdata_next = {AGPM_ZERO16, pe_dir_reg};
        AGPM_OFF_PE_DATA:   rdata_next = {AGPM_ZERO16, pe_dat_reg};
        AGPM_OFF_PIN_STATE: rdata_next = {16'h0000, pad_oe, pin_sync};
        default: begin
          rdata_next = 32'h0000_0000;
          rresp_next = AGPM_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // Registers the read answer.
  // Data and response are launched together with rvalid.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= AGPM_RESP_OKAY;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

endmodule

// ---- agpm_monitor.sv ----
// Concurrent checks on the pads of the pin mux.
`timescale 1ns/1ps
module agpm_monitor (
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [7:0]  emi_addr,
  input wire logic        emi_access,
  input wire logic [7:0]  pad_o,
  input wire logic [7:0]  pad_oe,
  input wire logic [7:0]  pad_pu
);
  logic        aw_f, w_f, fin, aw_h, w_h, pend, up;
  logic [7:0]  aw_a, wa, fs, e_o, e_oe;
  logic [31:0] w_d, wd;
  logic [3:0]  w_s, ws, pst;
  logic [2:0]  pix;
  logic [15:0] pdat;
  logic [15:0] sh [8];

  // Shadow of the register file, updated when a write completes.
  assign aw_f = s_axi_awvalid && s_axi_awready;
  assign w_f  = s_axi_wvalid && s_axi_wready;
  assign fin  = (aw_h || aw_f) && (w_h || w_f);
  assign wa   = aw_f ? s_axi_awaddr : aw_a;
  assign wd   = w_f ? s_axi_wdata : w_d;
  assign ws   = w_f ? s_axi_wstrb : w_s;
  assign fs   = sh[1][7:0];
  // The design commits a write one edge after both halves are in, so the
  // shadow waits one edge too; up marks the first edge after reset release.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_h <= 1'b0;
      w_h  <= 1'b0;
      pend <= 1'b0;
      up   <= 1'b0;
      sh   <= '{16'h0, 16'h0, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0};
    end else begin
      up   <= 1'b1;
      aw_h <= !fin && (aw_h || aw_f);
      w_h  <= !fin && (w_h || w_f);
      if (aw_f) aw_a <= s_axi_awaddr;
      if (w_f) w_d <= s_axi_wdata;
      if (w_f) w_s <= s_axi_wstrb;
      pend <= fin && wa < 8'h20 && wa[1:0] == 2'h0;
      pix  <= wa[4:2];
      pdat <= wd[15:0];
      pst  <= ws;
      if (pend && pst[0]) sh[pix][7:0] <= pdat[7:0];
      if (pend && pst[1]) sh[pix][15:8] <= pdat[15:8];
    end
  end

  // Expected port line value and enable of each pin.
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      e_o[k]  = k < 6 ? sh[5][k + 8] : sh[7][k - 4];
      e_oe[k] = k < 6 ? sh[4][k + 8] : sh[6][k - 4];
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_rst; disable iff (1'b0) !resetn |-> pad_oe == 8'h00 && pad_pu == 8'hFF; endproperty
  property p_dflt; $rose(resetn) |=> pad_o == emi_addr && pad_oe == {8{emi_access}}; endproperty
  property p_addr; up |-> (pad_o & ~fs) == (emi_addr & ~fs); endproperty
  property p_idle; up && !emi_access && !sh[0][0] |-> (pad_oe & ~fs) == 8'h00; endproperty
  property p_drv; up && (emi_access || sh[0][0]) |-> (pad_oe | fs) == 8'hFF; endproperty
  property p_gpio; up |-> (pad_oe & fs) == (e_oe & fs) && (pad_o & fs) == (e_o & fs);
  endproperty
  property p_papu; pad_pu[5:0] == sh[2][13:8]; endproperty
  property p_pepu; pad_pu[7:6] == sh[3][3:2]; endproperty
  a_rst: assert property (p_rst) else $error("pad state wrong in reset");
  a_dflt: assert property (p_dflt) else $error("pads not on bus after reset");
  a_addr: assert property (p_addr) else $error("address bit on wrong pad");
  a_idle: assert property (p_idle) else $error("idle pad driven");
  a_drv: assert property (p_drv) else $error("bus pad not driven");
  a_gpio: assert property (p_gpio) else $error("port line wrong");
  a_papu: assert property (p_papu) else $error("port A pull-up wrong");
  a_pepu: assert property (p_pepu) else $error("port E pull-up wrong");
  c_gpio: cover property ((pad_oe & fs) != 8'h00);
  c_drv: cover property (sh[0][0] && !emi_access);
  c_pu: cover property (pad_pu != 8'hFF);
endmodule

bind agpm_top agpm_monitor u_mon (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .emi_addr(emi_addr),
  .emi_access(emi_access), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu));

// ---- agpm_ext_mem.sv ----
// Model of the memory and board wiring on the shared pads.
`timescale 1ns/1ps
module agpm_ext_mem (
  input  wire logic       mclk,
  input  wire logic [7:0] pad_o,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pu,
  input  wire logic       emi_access,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_lvl,
  output logic      [7:0] mem_addr
);
  logic [7:0] last_reg = 8'h00;

  // A floating pad without pull-up drifts, so it never repeats its last level.
  assign pad_lvl = (pad_oe & pad_o) | (~pad_oe & ext_en & ext_val)
                 | (~pad_oe & ~ext_en & (pad_pu | ~last_reg));

  // Keeps the last level and takes the address during an access.
  always @(posedge mclk) begin
    last_reg <= pad_lvl;
    if (emi_access) mem_addr <= pad_lvl;
  end
endmodule

// ---- agpm_top_tb.sv ----
// Self-checking testbench for the pin mux.
`timescale 1ns/1ps
module agpm_top_tb;
  import agpm_pkg::*;
  logic        mclk = 0, resetn = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic [3:0]  wstrb = 4'hF;
  logic        arvalid = 0, rready = 0, emi_access = 0;
  logic [7:0]  awaddr = 0, araddr = 0, emi_addr = 0, ext_en = 0, ext_val = 0;
  logic [31:0] wdata = 0, lfsr = 32'hB7FB231C, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [7:0]  pad_i, pad_o, pad_oe, pad_pu;
  logic [15:0] sh [8];
  logic [23:0] e;
  int          err_count = 0, samples_checked = 0, cyc = 0;

  always #10 mclk = ~mclk;

  agpm_top DUT (.mclk(mclk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .emi_addr(emi_addr), .emi_access(emi_access), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe(pad_oe), .pad_pu(pad_pu));
  agpm_ext_mem u_mem (.mclk(mclk), .pad_o(pad_o), .pad_oe(pad_oe), .pad_pu(pad_pu),
    .emi_access(emi_access), .ext_en(ext_en), .ext_val(ext_val), .pad_lvl(pad_i),
    .mem_addr());

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction

  // Expected {pad_o, pad_oe, pad_pu} from the bench's register image.
  function automatic logic [23:0] exp_pins(input logic [7:0] a, input logic acc);
    logic [7:0] o, oe, pu;
    for (int k = 0; k < AGPM_NPINS; k++) begin
      pu[k] = k < 6 ? sh[2][k + AGPM_PA_LO] : sh[3][k - 6 + AGPM_PE_LO];
      o[k]  = k < 6 ? sh[5][k + AGPM_PA_LO] : sh[7][k - 6 + AGPM_PE_LO];
      oe[k] = k < 6 ? sh[4][k + AGPM_PA_LO] : sh[6][k - 6 + AGPM_PE_LO];
      if (!sh[1][k]) {o[k], oe[k]} = {a[k], acc | sh[0][AGPM_DRV_BIT]};
    end
    return {o, oe, pu};
  endfunction

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  // Write with both channels offered together, then the response.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'hF);
    @(posedge mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (awvalid || wvalid || !bvalid) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    chk("bresp", a < 8'h24 ? AGPM_RESP_OKAY : AGPM_RESP_SLVERR, bresp);
    if (a < AGPM_OFF_PIN_STATE && s[0]) sh[a[4:2]][7:0] = v[7:0];
    if (a < AGPM_OFF_PIN_STATE && s[1]) sh[a[4:2]][15:8] = v[15:8];
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rresp", a < 8'h24 ? AGPM_RESP_OKAY : AGPM_RESP_SLVERR, rresp);
    chk("rdata", x, rdata);
  endtask

  // Random bus traffic and board drive on the pads, compared each cycle.
  task automatic pins(input int n);
    repeat (n) begin
      lfsr = nxt(lfsr);
      @(posedge mclk);
      {ext_en, ext_val, emi_access, emi_addr} <= lfsr[24:0];
      #1;
      e = exp_pins(emi_addr, emi_access);
      chk("pad_o", e[23:16], pad_o);
      chk("pad_oe", e[15:8], pad_oe);
      chk("pad_pu", e[7:0], pad_pu);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    resetn <= 1'b0;
    repeat (2) begin
      sh = '{16'h0, 16'h0, 16'hFFFF, 16'hFFFF, 16'h0, 16'h0, 16'h0, 16'h0};
      repeat (6) @(posedge mclk);
      chk("rst_pads", 16'h00FF, {pad_oe, pad_pu});
      resetn <= 1'b1;
      pins(4);
      rd(AGPM_OFF_FUNC_SEL, 0);
      rd(AGPM_OFF_PA_PULLUP, 32'hFFFF);
      rd(AGPM_OFF_PE_PULLUP, 32'hFFFF);
      rd(8'h24, 0);
      wr(8'h30, 1);
      wr(AGPM_OFF_BUS_CTRL, 1);
      pins(6);
      for (int k = 0; k < 8; k++) begin
        wr(k < 6 ? AGPM_OFF_PA_PULLUP : AGPM_OFF_PE_PULLUP, 32'h0 | ~(16'h1 << (k < 6 ? k + 8 : k - 4)));
        pins(1);
      end
      repeat (30) begin
        lfsr = nxt(lfsr);
        wr({3'h0, lfsr[2:0], 2'h0}, lfsr, lfsr[31:28]);
        pins(2);
      end
      @(posedge mclk);
      ext_en <= 8'hFF;
      repeat (3) @(posedge mclk);
      e = exp_pins(emi_addr, emi_access);
      rd(AGPM_OFF_PIN_STATE, {e[15:8], (e[23:16] & e[15:8]) | (ext_val & ~e[15:8])});
      @(posedge mclk);
      resetn <= 1'b0;
    end
    conclude();
  end
endmodule
